// File: core/bar_readout.sv
// Purpose: Barometer module two-wire slave: calibration store plus converter.
// Assumes: Host is bus master, supplies the master clock and drives adc reset.
// Notes: Converter timing lives on the master clock; bus logic on clk_i.
// Overview of operation
// - Calibration store answers 0xA1 for reads and 0xA0 for pointer writes; no stored writes.
// - Converter answers 0xEE for writes and 0xEF for reads.
// - Calibration read is byte-address write then read, serial EEPROM style.
// - Coefficients at bytes 16..29 high byte first; curve params at 30..33.
// - Module acks address and command bytes; host acks MSB, nacks LSB.
// - Each result is a 16-bit unsigned word, high byte then low byte.
// - Converter runs from a continuous 32768 Hz master clock input.
`timescale 1ns/100ps
module bar_readout (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n_o,
    input wire logic mclk_i,
    input wire logic adc_reset_n_i,
    input wire logic [15:0] raw_pressure_i,
    input wire logic [15:0] raw_temperature_i,
    input wire logic cal_load_i,
    input wire logic [7:0] cal_load_addr_i,
    input wire logic [7:0] cal_load_data_i,
    output logic conv_busy_o
);

    // Bus pin synchronisers; the second and third stages feed edge detection
    logic scl_m, scl_s, scl_q;
    logic sda_m, sda_s, sda_q;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {scl_m, scl_s, scl_q} <= 3'h7;
            {sda_m, sda_s, sda_q} <= 3'h7;
        end else if (clk_en_i) begin
            {scl_m, scl_s, scl_q} <= {scl_i, scl_m, scl_s};
            {sda_m, sda_s, sda_q} <= {sda_i, sda_m, sda_s};
        end
    end

    logic scl_rise, scl_fall, start_seen, stop_seen;
    assign scl_rise = scl_s & ~scl_q;
    assign scl_fall = ~scl_s & scl_q;
    assign start_seen = scl_s & scl_q & sda_q & ~sda_s;
    assign stop_seen = scl_s & scl_q & ~sda_q & sda_s;

    // Open drain: only ever pulls low
    assign sda_o = 1'b0;

    // Address acceptance; dummy write to the store only sets the pointer
    function automatic logic addr_match(input logic [7:0] b);
        addr_match = (b == bar_pkg::CAL_ADDR_RD) || (b == bar_pkg::CAL_ADDR_WR)
            || (b == bar_pkg::ADC_ADDR_WR) || (b == bar_pkg::ADC_ADDR_RD);
    endfunction : addr_match

    // Link state
    bar_pkg::bar_link_state_e state, next_state;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic release_sda, next_release_sda;
    logic to_adc, next_to_adc;
    logic rd_dir, next_rd_dir;
    logic first_wr, next_first_wr;
    logic conv_prefix, next_conv_prefix;
    logic host_nack, next_host_nack;
    logic [7:0] cal_ptr, next_cal_ptr;
    logic [1:0] res_idx, next_res_idx;
    logic start_tgl, next_start_tgl;
    logic conv_is_press, next_conv_is_press;
    logic busy, next_busy;
    logic [15:0] result, next_result;

    // Converter-side signals crossing back
    logic done_tgl;
    logic [15:0] conv_word;
    logic done_m, done_s, done_q;
    logic done_edge;
    assign done_edge = done_s ^ done_q;

    // Done toggle synchroniser; word is stable once the toggle lands
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {done_m, done_s, done_q} <= 3'h0;
        end else if (clk_en_i) begin
            {done_m, done_s, done_q} <= {done_tgl, done_m, done_s};
        end
    end

    logic [7:0] cal_rdata;
    bar_cal_store u_cal_store (
        .clk_i(clk_i),
        .clk_en_i(clk_en_i),
        .load_i(cal_load_i),
        .load_addr_i(cal_load_addr_i),
        .load_data_i(cal_load_data_i),
        .rd_addr_i(cal_ptr),
        .rd_data_o(cal_rdata)
    );

    // Byte to send next: store byte, or result high then low
    logic [7:0] tx_byte;
    always_comb begin
        if (!to_adc) begin
            tx_byte = cal_rdata;
        end else if (res_idx == 2'h0) begin
            tx_byte = result[15:8];
        end else if (res_idx == 2'h1) begin
            tx_byte = result[7:0];
        end else begin
            tx_byte = bar_pkg::IDLE_READ_BYTE;
        end
    end

    // Bit engine: SDA only changes after SCL falls
    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shift = shift;
        next_release_sda = release_sda;
        next_to_adc = to_adc;
        next_rd_dir = rd_dir;
        next_first_wr = first_wr;
        next_conv_prefix = conv_prefix;
        next_host_nack = host_nack;
        next_cal_ptr = cal_ptr;
        next_res_idx = res_idx;
        next_start_tgl = start_tgl;
        next_conv_is_press = conv_is_press;
        next_busy = busy;
        next_result = result;
        if (done_edge) begin
            next_busy = 1'b0;
            next_result = conv_word;
        end
        if (start_seen) begin
            next_state = bar_pkg::ST_ADDR;
            next_bit_cnt = 4'h0;
            next_release_sda = 1'b1;
        end else if (stop_seen) begin
            next_state = bar_pkg::ST_IDLE;
            next_release_sda = 1'b1;
        end else if (scl_rise) begin
            case (state)
                bar_pkg::ST_ADDR, bar_pkg::ST_WRITE: begin
                    if (bit_cnt != bar_pkg::BITS_PER_BYTE) begin
                        next_shift = {shift[6:0], sda_s};
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end
                bar_pkg::ST_READ_ACK: begin
                    next_host_nack = sda_s;
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (state)
                bar_pkg::ST_ADDR: begin
                    if (bit_cnt == bar_pkg::BITS_PER_BYTE) begin
                        if (addr_match(shift)) begin
                            next_release_sda = 1'b0;
                            next_state = bar_pkg::ST_ADDR_ACK;
                            next_to_adc = (shift[7:1] == bar_pkg::ADC_ADDR_WR[7:1]);
                            next_rd_dir = shift[0];
                            next_first_wr = 1'b1;
                            next_conv_prefix = 1'b0;
                        end else begin
                            next_state = bar_pkg::ST_SKIP;
                        end
                    end
                end
                bar_pkg::ST_ADDR_ACK: begin
                    next_bit_cnt = 4'h0;
                    next_release_sda = 1'b1;
                    next_state = bar_pkg::ST_WRITE;
                    if (rd_dir) begin
                        next_shift = tx_byte;
                        next_release_sda = tx_byte[7];
                        next_bit_cnt = 4'h1;
                        next_state = bar_pkg::ST_READ;
                    end
                end
                bar_pkg::ST_WRITE: begin
                    if (bit_cnt == bar_pkg::BITS_PER_BYTE) begin
                        next_first_wr = 1'b0;
                        next_state = bar_pkg::ST_SKIP;
                        if (!to_adc) begin
                            if (first_wr) begin
                                next_cal_ptr = shift;
                                next_release_sda = 1'b0;
                                next_state = bar_pkg::ST_WRITE_ACK;
                            end
                        end else if (first_wr && shift == bar_pkg::CMD_CONV_PREFIX) begin
                            next_conv_prefix = 1'b1;
                            next_release_sda = 1'b0;
                            next_state = bar_pkg::ST_WRITE_ACK;
                        end else if (first_wr && shift == bar_pkg::CMD_READ_RESULT) begin
                            next_res_idx = 2'h0;
                            next_release_sda = 1'b0;
                            next_state = bar_pkg::ST_WRITE_ACK;
                        end else if (conv_prefix && !busy
                            && (shift == bar_pkg::CMD_CONV_PRESSURE
                            || shift == bar_pkg::CMD_CONV_TEMPERATURE)) begin
                            next_conv_is_press = (shift == bar_pkg::CMD_CONV_PRESSURE);
                            next_start_tgl = ~start_tgl;
                            next_busy = 1'b1;
                            next_conv_prefix = 1'b0;
                            next_release_sda = 1'b0;
                            next_state = bar_pkg::ST_WRITE_ACK;
                        end
                    end
                end
                bar_pkg::ST_WRITE_ACK: begin
                    next_release_sda = 1'b1;
                    next_bit_cnt = 4'h0;
                    next_state = bar_pkg::ST_WRITE;
                end
                bar_pkg::ST_READ: begin
                    if (bit_cnt == bar_pkg::BITS_PER_BYTE) begin
                        next_release_sda = 1'b1;
                        next_state = bar_pkg::ST_READ_ACK;
                        if (to_adc) begin
                            if (res_idx != 2'h2) begin
                                next_res_idx = res_idx + 2'h1;
                            end
                        end else begin
                            next_cal_ptr = cal_ptr + 8'h01;
                        end
                    end else begin
                        next_shift = {shift[6:0], 1'b0};
                        next_release_sda = shift[6];
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                end
                bar_pkg::ST_READ_ACK: begin
                    if (host_nack) begin
                        next_state = bar_pkg::ST_SKIP;
                    end else begin
                        next_shift = tx_byte;
                        next_release_sda = tx_byte[7];
                        next_bit_cnt = 4'h1;
                        next_state = bar_pkg::ST_READ;
                    end
                end
                default: begin
                    next_release_sda = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= bar_pkg::ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            release_sda <= 1'b1;
            to_adc <= 1'b0;
            rd_dir <= 1'b0;
            first_wr <= 1'b0;
            conv_prefix <= 1'b0;
            host_nack <= 1'b1;
            cal_ptr <= 8'h00;
            res_idx <= 2'h0;
            start_tgl <= 1'b0;
            conv_is_press <= 1'b0;
            busy <= 1'b0;
            result <= bar_pkg::RESULT_RESET;
        end else if (clk_en_i) begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shift <= next_shift;
            release_sda <= next_release_sda;
            to_adc <= next_to_adc;
            rd_dir <= next_rd_dir;
            first_wr <= next_first_wr;
            conv_prefix <= next_conv_prefix;
            host_nack <= next_host_nack;
            cal_ptr <= next_cal_ptr;
            res_idx <= next_res_idx;
            start_tgl <= next_start_tgl;
            conv_is_press <= next_conv_is_press;
            busy <= next_busy;
            result <= next_result;
        end
    end

    assign sda_oe_n_o = release_sda;
    assign conv_busy_o = busy;

    // Master-clock domain: start toggle and adc reset pin synchronisers
    logic st_m, st_s, st_q;
    logic arst_m, arst_s;
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            {st_m, st_s, st_q} <= 3'h0;
            {arst_m, arst_s} <= 2'h0;
        end else begin
            {st_m, st_s, st_q} <= {start_tgl, st_m, st_s};
            {arst_m, arst_s} <= {adc_reset_n_i, arst_m};
        end
    end

    // Converter sequencer; kind bit is stable well before the toggle lands
    bar_pkg::bar_conv_state_e cv_state, next_cv_state;
    logic [10:0] cv_cnt, next_cv_cnt;
    logic [15:0] next_conv_word;
    logic next_done_tgl;
    always_comb begin
        next_cv_state = cv_state;
        next_cv_cnt = cv_cnt;
        next_conv_word = conv_word;
        next_done_tgl = done_tgl;
        case (cv_state)
            bar_pkg::CV_IDLE: begin
                if (st_s ^ st_q) begin
                    if (arst_s) begin
                        next_cv_state = bar_pkg::CV_RUN;
                        next_cv_cnt = 11'h000;
                    end else begin
                        // Held in reset: finish at once so busy cannot stick
                        next_conv_word = bar_pkg::RESULT_RESET;
                        next_done_tgl = ~done_tgl;
                    end
                end
            end
            bar_pkg::CV_RUN: begin
                if (!arst_s) begin
                    next_conv_word = bar_pkg::RESULT_RESET;
                    next_done_tgl = ~done_tgl;
                    next_cv_state = bar_pkg::CV_IDLE;
                end else if (cv_cnt == bar_pkg::CONV_LAST) begin
                    next_conv_word = conv_is_press ? raw_pressure_i : raw_temperature_i;
                    next_done_tgl = ~done_tgl;
                    next_cv_state = bar_pkg::CV_IDLE;
                end else begin
                    next_cv_cnt = cv_cnt + 11'h001;
                end
            end
            default: begin
                next_cv_state = bar_pkg::CV_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cv_state <= bar_pkg::CV_IDLE;
            cv_cnt <= 11'h000;
            conv_word <= bar_pkg::RESULT_RESET;
            done_tgl <= 1'b0;
        end else begin
            cv_state <= next_cv_state;
            cv_cnt <= next_cv_cnt;
            conv_word <= next_conv_word;
            done_tgl <= next_done_tgl;
        end
    end

endmodule : bar_readout

// File: core/bar_pkg.sv
// Purpose: Shared constants and state types for the barometer readout block.
// Assumes: 100 MHz system clock; converter master clock of 32768 Hz.
// Notes: Two-wire addresses are full 8-bit bytes including the R/W bit.
package bar_pkg;

    // Two-wire bus addresses (address byte with R/W bit)
    localparam logic [7:0] CAL_ADDR_RD = 8'hA1;
    localparam logic [7:0] CAL_ADDR_WR = 8'hA0;
    localparam logic [7:0] ADC_ADDR_WR = 8'hEE;
    localparam logic [7:0] ADC_ADDR_RD = 8'hEF;

    // Converter command bytes
    localparam logic [7:0] CMD_CONV_PREFIX = 8'hFF;
    localparam logic [7:0] CMD_CONV_PRESSURE = 8'hF0;
    localparam logic [7:0] CMD_CONV_TEMPERATURE = 8'hE8;
    localparam logic [7:0] CMD_READ_RESULT = 8'hFD;

    // Calibration store layout: seven coefficients high byte first, then A..D
    localparam logic [7:0] CAL_COEF_FIRST = 8'h10;
    localparam logic [7:0] CAL_COEF_LAST = 8'h1D;
    localparam logic [7:0] CAL_CURVE_FIRST = 8'h1E;
    localparam logic [7:0] CAL_CURVE_LAST = 8'h21;
    localparam int CAL_DEPTH = 256;
    localparam int CAL_AW = 8;

    // Bit engine counts
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [7:0] IDLE_READ_BYTE = 8'hFF;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // Conversion timing: longest time, so the count rounds down
    localparam int MCLK_HZ = 32768;
    localparam int CONV_TIME_MS = 35;
    localparam int CONV_CYCLES = (CONV_TIME_MS * MCLK_HZ) / 1000;
    localparam logic [10:0] CONV_LAST = 11'(CONV_CYCLES - 1);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WRITE,
        ST_WRITE_ACK,
        ST_READ,
        ST_READ_ACK,
        ST_SKIP
    } bar_link_state_e;

    typedef enum logic [0:0] {
        CV_IDLE,
        CV_RUN
    } bar_conv_state_e;

endpackage : bar_pkg

// File: core/bar_cal_store.sv
// Purpose: Read-only calibration byte store seen from the two-wire bus.
// Assumes: Contents are loaded once through the factory port.
// Notes: Read data is registered; address must be stable one cycle ahead.
`timescale 1ns/100ps
module bar_cal_store (
    input wire logic clk_i,
    input wire logic clk_en_i,
    input wire logic load_i,
    input wire logic [bar_pkg::CAL_AW-1:0] load_addr_i,
    input wire logic [7:0] load_data_i,
    input wire logic [bar_pkg::CAL_AW-1:0] rd_addr_i,
    output logic [7:0] rd_data_o
);

    logic [7:0] mem [bar_pkg::CAL_DEPTH];

    // Factory load only; the bus side has no write path into here
    always_ff @(posedge clk_i) begin
        if (clk_en_i) begin
            if (load_i) begin
                mem[load_addr_i] <= load_data_i;
            end
            rd_data_o <= mem[rd_addr_i];
        end
    end

endmodule : bar_cal_store

// File: testbench/bar_readout_sva.sv
// Purpose: Port checker for the barometer readout block.
// Assumes: Converter clock runs 16 system clocks a period in the bench.
// Notes: Bound to bar_readout at the foot of this file.
`timescale 1ns/100ps
module bar_readout_sva (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic clk_en_i,
    input wire logic scl_i,
    input wire logic sda_o,
    input wire logic sda_oe_n_o,
    input wire logic conv_busy_o
);
    // Longest busy span: 1160 converter periods of 16 clocks
    localparam int BUSY_MAX = 18560;
    logic [15:0] busy_cnt;
    logic [15:0] next_busy_cnt;

    // Busy length counter; too long for a repetition
    always_comb begin
        next_busy_cnt = conv_busy_o ? busy_cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= next_busy_cnt;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_idle_out;
        sda_oe_n_o && !conv_busy_o;
    endsequence
    sequence s_busy_run;
        conv_busy_o [*8];
    endsequence

    property p_release_idle;
        $rose(reset_n_i) |-> s_idle_out;
    endproperty
    property p_open_drain;
        sda_o == 1'b0;
    endproperty
    // Drive changes only once the clock pin has been low a while
    property p_drive_scl_low;
        $changed(sda_oe_n_o) |-> !scl_i && !$past(scl_i) && !$past(scl_i, 2);
    endproperty
    property p_high_stable;
        scl_i && $past(scl_i) |-> $stable(sda_oe_n_o);
    endproperty
    property p_busy_on_ack;
        $rose(conv_busy_o) |-> !sda_oe_n_o;
    endproperty
    property p_busy_min;
        $rose(conv_busy_o) |-> s_busy_run;
    endproperty
    property p_busy_max;
        conv_busy_o |-> busy_cnt < BUSY_MAX;
    endproperty
    property p_freeze;
        !clk_en_i |=> $stable(sda_oe_n_o) && $stable(conv_busy_o);
    endproperty

    a_release_idle: assert property (p_release_idle)
        else $error("outputs not idle after reset");
    a_open_drain: assert property (p_open_drain)
        else $error("data pin value not zero");
    a_drive_scl_low: assert property (p_drive_scl_low)
        else $error("data drive changed near clock high");
    a_high_stable: assert property (p_high_stable)
        else $error("data drive changed while clock high");
    a_busy_on_ack: assert property (p_busy_on_ack)
        else $error("busy rose without acknowledge");
    a_busy_min: assert property (p_busy_min)
        else $error("conversion ended too soon");
    a_busy_max: assert property (p_busy_max)
        else $error("conversion ran too long");
    a_freeze: assert property (p_freeze)
        else $error("outputs moved while clock enable low");
endmodule : bar_readout_sva

bind bar_readout bar_readout_sva i_sva (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i),
    .scl_i(scl_i),
    .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o),
    .conv_busy_o(conv_busy_o)
);

// File: testbench/bar_host_model.sv
// Purpose: Host side of the bus: master, converter clock and reset pin.
// Assumes: Data line has a pull-up; released means 1.
// Notes: Four quarter periods a bit; all moves just after a clock edge.
`timescale 1ns/100ps
module bar_host_model #(
    parameter int QTR = 25
) (
    input wire logic clk_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o,
    output logic mclk_o,
    output logic adc_reset_n_o
);
    // Free-running converter clock, phase unrelated to clk_i
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
        adc_reset_n_o = 1'b0;
        mclk_o = 1'b0;
        #37;
        forever #80 mclk_o = ~mclk_o;
    end

    task qwait();
        repeat (QTR) @(posedge clk_i);
        #1;
    endtask : qwait

    // Pin held low while idle, raised ahead of a conversion
    task set_adc(input logic v);
        adc_reset_n_o = v;
        repeat (64) @(posedge clk_i);
        #1;
    endtask : set_adc

    // Sample mid high phase so device edges have settled
    task put_bit(input logic b, output logic r);
        sda_o = b;
        qwait();
        scl_o = 1'b1;
        qwait();
        r = sda_i;
        qwait();
        scl_o = 1'b0;
        qwait();
    endtask : put_bit

    task start_cond();
        sda_o = 1'b1;
        qwait();
        scl_o = 1'b1;
        qwait();
        sda_o = 1'b0;
        qwait();
        scl_o = 1'b0;
        qwait();
    endtask : start_cond

    task stop_cond();
        sda_o = 1'b0;
        qwait();
        scl_o = 1'b1;
        qwait();
        sda_o = 1'b1;
        qwait();
    endtask : stop_cond

    task send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(d[i], r);
        end
        put_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    // Nack leaves the line released, as a 1
    task recv_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            put_bit(1'b1, r);
            d[i] = r;
        end
        put_bit(~ack, r);
    endtask : recv_byte
endmodule : bar_host_model

// File: testbench/barometer_i2c_readout_tb.sv
// Purpose: Self-checking bench for the barometer readout block.
// Assumes: 100 MHz system clock, converter clock from the host model.
// Notes: Host delay is scaled to the bench master clock period.
`timescale 1ns/100ps
module barometer_i2c_readout_tb;
    logic clk, reset_n, clk_en, scl, host_sda, dut_sda, dut_oe_n, sda;
    logic mclk, adc_reset_n, cal_load, busy;
    logic [7:0] cal_addr, cal_data;
    logic [15:0] raw_p, raw_t, first_word;
    // 1311 master periods of 160 ns: over 40 ms at 32768 Hz
    localparam int HOST_WAIT_NS = 209760;
    int miscompares = 0;
    int check_count = 0;

    // Wired-and bus with pull-up
    assign sda = host_sda & (dut_oe_n | dut_sda);

    bar_readout i_dut (
        .clk_i(clk), .reset_n_i(reset_n), .clk_en_i(clk_en), .scl_i(scl),
        .sda_i(sda), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n), .mclk_i(mclk),
        .adc_reset_n_i(adc_reset_n), .raw_pressure_i(raw_p),
        .raw_temperature_i(raw_t), .cal_load_i(cal_load),
        .cal_load_addr_i(cal_addr), .cal_load_data_i(cal_data),
        .conv_busy_o(busy)
    );
    bar_host_model i_host (
        .clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(host_sda),
        .mclk_o(mclk), .adc_reset_n_o(adc_reset_n)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [7:0] pat(input int a);
        return 8'(a * 37 + 11);
    endfunction : pat

    task test_done();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : test_done

    task automatic chk_ack(input string name, input logic exp, input logic got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk_ack

    task automatic chk_word(input string name, input logic [15:0] exp,
                            input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic wb(input logic [7:0] d, input logic exp, input string name);
        logic a;
        i_host.send_byte(d, a);
        chk_ack(name, exp, a);
    endtask : wb

    // Store is not reset, so fill it before any read
    task automatic load_store();
        for (int a = 0; a < 256; a++) begin
            cal_load = 1'b1;
            cal_addr = 8'(a);
            cal_data = pat(a);
            @(posedge clk);
            #1;
        end
        cal_load = 1'b0;
    endtask : load_store

    // Write attempt at 16 must leave the pattern in place
    task automatic t_cal();
        logic [7:0] hi, lo;
        i_host.start_cond();
        wb(bar_pkg::CAL_ADDR_WR, 1'b1, "ptr addr");
        wb(bar_pkg::CAL_COEF_FIRST, 1'b1, "ptr");
        wb(8'h55, 1'b0, "store write");
        i_host.stop_cond();
        i_host.start_cond();
        wb(bar_pkg::CAL_ADDR_WR, 1'b1, "ptr addr");
        wb(bar_pkg::CAL_COEF_FIRST, 1'b1, "ptr");
        i_host.start_cond();
        wb(bar_pkg::CAL_ADDR_RD, 1'b1, "store read");
        for (int a = 16; a < 34; a += 2) begin
            i_host.recv_byte(1'b1, hi);
            i_host.recv_byte(a != 32, lo);
            chk_word("cal pair", {pat(a), pat(a + 1)}, {hi, lo});
        end
        i_host.stop_cond();
    endtask : t_cal

    task automatic t_refuse();
        logic [7:0] bad [3] = '{8'hA2, 8'hEC, 8'h40};
        foreach (bad[i]) begin
            i_host.start_cond();
            wb(bad[i], 1'b0, "foreign addr");
            i_host.stop_cond();
        end
        i_host.start_cond();
        wb(bar_pkg::ADC_ADDR_WR, 1'b1, "conv addr");
        wb(bar_pkg::CMD_CONV_PREFIX, 1'b1, "prefix");
        wb(8'h12, 1'b0, "bad cmd");
        i_host.stop_cond();
    endtask : t_refuse

    // Select the result, then high byte (ack) and low byte (nack)
    task automatic rd_result(output logic [15:0] w);
        logic [7:0] hi, lo;
        i_host.start_cond();
        wb(bar_pkg::ADC_ADDR_WR, 1'b1, "conv addr");
        wb(bar_pkg::CMD_READ_RESULT, 1'b1, "select");
        i_host.start_cond();
        wb(bar_pkg::ADC_ADDR_RD, 1'b1, "result addr");
        i_host.recv_byte(1'b1, hi);
        i_host.recv_byte(1'b0, lo);
        i_host.stop_cond();
        w = (16'(hi) << 8) | 16'(lo);
    endtask : rd_result

    // Second start while busy is refused; result read high byte first
    task automatic t_conv(input logic [7:0] cmd, input logic [15:0] exp);
        logic [15:0] w;
        time t0;
        i_host.set_adc(1'b1);
        for (int k = 0; k < 2; k++) begin
            i_host.start_cond();
            wb(bar_pkg::ADC_ADDR_WR, 1'b1, "conv addr");
            wb(bar_pkg::CMD_CONV_PREFIX, 1'b1, "prefix");
            wb(cmd, k == 0, "conv cmd");
            i_host.stop_cond();
            if (k == 0) begin
                t0 = $time;
            end
            chk_ack("busy", 1'b1, busy);
        end
        // Host delay counted from the stop of the accepted command
        while ($time - t0 < HOST_WAIT_NS) begin
            @(posedge clk);
            #1;
        end
        chk_ack("done", 1'b0, busy);
        rd_result(w);
        chk_word("result", exp, w);
        i_host.set_adc(1'b0);
    endtask : t_conv

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        test_done();
    end

    // Reset is asynchronous, so both clock domains clear at once
    initial begin
        clk_en = 1'b1;
        reset_n = 1'b0;
        cal_load = 1'b0;
        cal_addr = 8'h00;
        cal_data = 8'h00;
        raw_p = 16'hFFFF;
        raw_t = 16'h00FE;
        repeat (5) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (5) @(posedge clk);
        #1;
        load_store();
        clk_en = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        clk_en = 1'b1;
        t_cal();
        t_refuse();
        // Host throws the power-up read away; only its reset value is checked
        rd_result(first_word);
        chk_word("power-up result", bar_pkg::RESULT_RESET, first_word);
        t_conv(bar_pkg::CMD_CONV_PRESSURE, 16'hFFFF);
        t_conv(bar_pkg::CMD_CONV_TEMPERATURE, 16'h00FE);
        test_done();
    end
endmodule : barometer_i2c_readout_tb
